/* File: hdl/dpdc_pkg.sv */
// Operation
// - phase direction bit 19, resets to one
// - add signed base offset to base phases
// - unwrap enable combines two frequency frames
// - decode ratio field into frequency ratio
// - supplementary subframe count field, reset four
// - alternate enable interleaves alternate frames
// - statistics select bit 5, resets zero
// - add signed supplementary offset to supplementary phases
package dpdc_pkg;
   localparam int unsigned REG_W = 24;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned PHASE_W = 12;
   localparam int unsigned OFFS_W = 13;
   localparam logic [7:0] IDX_SUPP_OFFSET = 8'hf5;
   localparam logic [7:0] IDX_PHASE_DIR = 8'hf9;
   localparam logic [7:0] IDX_ALT_FRAME = 8'hfb;
   localparam logic [7:0] IDX_OUT_CONTENT = 8'hfe;
   localparam logic [REG_W-1:0] RST_SUPP_OFFSET = 24'h000000;
   localparam logic [REG_W-1:0] RST_PHASE_DIR = 24'h080000;
   localparam logic [REG_W-1:0] RST_ALT_FRAME = 24'h01e008;
   localparam logic [REG_W-1:0] RST_OUT_CONTENT = 24'h21090f;
   localparam int unsigned POS_FLIP = 19;
   localparam int unsigned POS_OFFS_LSB = 0;
   localparam int unsigned POS_UNWRAP_EN = 11;
   localparam int unsigned POS_RATIO_LSB = 8;
   localparam int unsigned POS_SUBCNT_LSB = 1;
   localparam int unsigned POS_ALT_EN = 0;
   localparam int unsigned POS_STATS_EN = 5;
endpackage : dpdc_pkg

/* File: hdl/dpdc_phase_if.sv */
`timescale 1ns/100ps
interface dpdc_phase_if;
   import dpdc_pkg::*;
   logic in_valid;
   logic [PHASE_W-1:0] in_phase;
   logic flip;
   logic [OFFS_W-1:0] offset;
   logic out_valid;
   logic [PHASE_W-1:0] out_phase;
   modport ctl (output in_valid, output in_phase, output flip, output offset, input out_valid, input out_phase);
   modport adj (input in_valid, input in_phase, input flip, input offset, output out_valid, output out_phase);
endinterface : dpdc_phase_if

/* File: hdl/dpdc_phase_adj.sv */
`timescale 1ns/100ps
module dpdc_phase_adj (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   dpdc_phase_if.adj pif
);
   import dpdc_pkg::*;
   logic [PHASE_W-1:0] dir_phase;
   logic [PHASE_W-1:0] out_phase_ff;
   logic out_valid_ff;

   // direction bit low reverses the phase sense
   assign dir_phase = pif.flip ? pif.in_phase : PHASE_W'(-pif.in_phase);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_valid_ff <= 1'b0;
         out_phase_ff <= '0;
      end else if (ce) begin
         out_valid_ff <= pif.in_valid;
         // signed offset, result wraps modulo the phase range
         if (pif.in_valid) begin
            out_phase_ff <= dir_phase + pif.offset[PHASE_W-1:0];
         end
      end
   end

   assign pif.out_valid = out_valid_ff;
   assign pif.out_phase = out_phase_ff;
endmodule : dpdc_phase_adj

/* File: hdl/dpdc_top.sv */
`timescale 1ns/100ps
module dpdc_top (
   core_clk,
   rst,
   ce,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   frame_start,
   phase_valid,
   phase_data,
   corr_phase_valid,
   corr_phase,
   frame_is_alt,
   dual_frequency_unwrap_enable,
   alternate_frame_enable,
   alternate_frequency_ratio,
   supplementary_subframe_count,
   statistics_select,
   unwrap_pair_done
);
   import dpdc_pkg::*;
   input wire logic core_clk;
   input wire logic rst;
   input wire logic ce;
   input wire logic psel;
   input wire logic penable;
   input wire logic pwrite;
   input wire logic [dpdc_pkg::ADDR_W-1:0] paddr;
   input wire logic [31:0] pwdata;
   output logic [31:0] prdata;
   output logic pready;
   output logic pslverr;
   input wire logic frame_start;
   input wire logic phase_valid;
   input wire logic [dpdc_pkg::PHASE_W-1:0] phase_data;
   output logic corr_phase_valid;
   output logic [dpdc_pkg::PHASE_W-1:0] corr_phase;
   output logic frame_is_alt;
   output logic dual_frequency_unwrap_enable;
   output logic alternate_frame_enable;
   output logic [6:0] alternate_frequency_ratio;
   output logic [6:0] supplementary_subframe_count;
   output logic statistics_select;
   output logic unwrap_pair_done;

   logic [REG_W-1:0] supp_offset_ff;
   logic [REG_W-1:0] phase_dir_ff;
   logic [REG_W-1:0] alt_frame_ff;
   logic [REG_W-1:0] out_content_ff;
   logic act_flip_ff;
   logic [OFFS_W-1:0] act_base_offset_ff;
   logic [OFFS_W-1:0] act_supp_offset_ff;
   logic act_unwrap_ff;
   logic [2:0] act_ratio_ff;
   logic [6:0] act_subcnt_ff;
   logic act_alt_en_ff;
   logic act_stats_ff;
   logic frame_is_alt_ff;
   logic pair_done_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic [7:0] acc_idx;
   logic acc_hit;
   logic acc_go;
   logic [REG_W-1:0] rd_mux;
   logic nxt_frame_is_alt;
   dpdc_phase_if pif ();

   // register index is the word address; byte address is four times it
   assign acc_idx = paddr[9:2];
   assign acc_go = psel && penable && ce;
   always_comb begin
      acc_hit = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
      rd_mux = '0;
      case (acc_idx)
         IDX_SUPP_OFFSET: rd_mux = supp_offset_ff;
         IDX_PHASE_DIR: rd_mux = phase_dir_ff;
         IDX_ALT_FRAME: rd_mux = alt_frame_ff;
         IDX_OUT_CONTENT: rd_mux = out_content_ff;
         default: acc_hit = 1'b0;
      endcase
   end

   // software-visible copies, written as-is
   always_ff @(posedge core_clk) begin
      if (rst) begin
         supp_offset_ff <= RST_SUPP_OFFSET;
         phase_dir_ff <= RST_PHASE_DIR;
         alt_frame_ff <= RST_ALT_FRAME;
         out_content_ff <= RST_OUT_CONTENT;
      end else if (acc_go && pwrite && acc_hit) begin
         case (acc_idx)
            IDX_SUPP_OFFSET: supp_offset_ff <= pwdata[REG_W-1:0];
            IDX_PHASE_DIR: phase_dir_ff <= pwdata[REG_W-1:0];
            IDX_ALT_FRAME: alt_frame_ff <= pwdata[REG_W-1:0];
            IDX_OUT_CONTENT: out_content_ff <= pwdata[REG_W-1:0];
            default: supp_offset_ff <= supp_offset_ff;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else if (ce && psel && !penable) begin
         prdata_ff <= {8'h00, rd_mux};
         pslverr_ff <= !acc_hit;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;

   // active settings load only at a frame boundary
   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_flip_ff <= RST_PHASE_DIR[POS_FLIP];
         act_base_offset_ff <= RST_PHASE_DIR[POS_OFFS_LSB +: OFFS_W];
         act_supp_offset_ff <= RST_SUPP_OFFSET[POS_OFFS_LSB +: OFFS_W];
         act_unwrap_ff <= RST_ALT_FRAME[POS_UNWRAP_EN];
         act_ratio_ff <= RST_ALT_FRAME[POS_RATIO_LSB +: 3];
         act_subcnt_ff <= RST_ALT_FRAME[POS_SUBCNT_LSB +: 7];
         act_alt_en_ff <= RST_ALT_FRAME[POS_ALT_EN];
         act_stats_ff <= RST_OUT_CONTENT[POS_STATS_EN];
      end else if (ce && frame_start) begin
         act_flip_ff <= phase_dir_ff[POS_FLIP];
         act_base_offset_ff <= phase_dir_ff[POS_OFFS_LSB +: OFFS_W];
         act_supp_offset_ff <= supp_offset_ff[POS_OFFS_LSB +: OFFS_W];
         act_unwrap_ff <= alt_frame_ff[POS_UNWRAP_EN];
         act_ratio_ff <= alt_frame_ff[POS_RATIO_LSB +: 3];
         act_subcnt_ff <= alt_frame_ff[POS_SUBCNT_LSB +: 7];
         act_alt_en_ff <= alt_frame_ff[POS_ALT_EN];
         act_stats_ff <= out_content_ff[POS_STATS_EN];
      end
   end

   // base and alternate frames take turns while alternate frames are on
   assign nxt_frame_is_alt = alt_frame_ff[POS_ALT_EN] && !frame_is_alt_ff;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         frame_is_alt_ff <= 1'b1;
      end else if (ce && frame_start) begin
         frame_is_alt_ff <= nxt_frame_is_alt;
      end
   end

   // a finished alternate frame closes a base/alternate pair for unwrapping
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pair_done_ff <= 1'b0;
      end else if (ce) begin
         pair_done_ff <= frame_start && frame_is_alt_ff && act_alt_en_ff && act_unwrap_ff;
      end
   end

   always_comb begin
      case (act_ratio_ff)
         3'h0: alternate_frequency_ratio = 7'h02;
         3'h1: alternate_frequency_ratio = 7'h04;
         3'h2: alternate_frequency_ratio = 7'h08;
         3'h3: alternate_frequency_ratio = 7'h10;
         3'h4: alternate_frequency_ratio = 7'h20;
         3'h5: alternate_frequency_ratio = 7'h40;
         3'h6: alternate_frequency_ratio = 7'h00;
         default: alternate_frequency_ratio = 7'h01;
      endcase
   end

   // supplementary frames take their own offset
   assign pif.in_valid = phase_valid && ce;
   assign pif.in_phase = phase_data;
   assign pif.flip = act_flip_ff;
   assign pif.offset = (frame_is_alt_ff && act_alt_en_ff) ? act_supp_offset_ff : act_base_offset_ff;

   dpdc_phase_adj u_adj (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .pif(pif)
   );

   assign corr_phase_valid = pif.out_valid;
   assign corr_phase = pif.out_phase;
   assign frame_is_alt = frame_is_alt_ff && act_alt_en_ff;
   assign dual_frequency_unwrap_enable = act_unwrap_ff;
   assign alternate_frame_enable = act_alt_en_ff;
   assign supplementary_subframe_count = act_subcnt_ff;
   assign statistics_select = act_stats_ff;
   assign unwrap_pair_done = pair_done_ff;
endmodule : dpdc_top

/* File: dv/dpdc_properties.sv */
`timescale 1ns/100ps
module dpdc_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic frame_start,
   input wire logic phase_valid,
   input wire logic corr_phase_valid,
   input wire logic [dpdc_pkg::PHASE_W-1:0] corr_phase,
   input wire logic frame_is_alt,
   input wire logic dual_frequency_unwrap_enable,
   input wire logic alternate_frame_enable,
   input wire logic [6:0] alternate_frequency_ratio,
   input wire logic [6:0] supplementary_subframe_count,
   input wire logic statistics_select,
   input wire logic unwrap_pair_done
);
   import dpdc_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence frame_edge;
      frame_start && ce;
   endsequence
   sequence pair_end;
      frame_edge ##0 (frame_is_alt && alternate_frame_enable && dual_frequency_unwrap_enable);
   endsequence
   ratio_legal_a: assert property (alternate_frequency_ratio inside {7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20,
      7'h40}) else $error("ratio out of set");
   reset_fields_a: assert property ($fell(rst) |-> supplementary_subframe_count == 7'h04 && !statistics_select)
      else $error("bad reset fields");
   settings_hold_a: assert property (!(frame_start && ce) |=> $stable(alternate_frame_enable) && $stable(frame_is_alt)
      && $stable(dual_frequency_unwrap_enable) && $stable(supplementary_subframe_count)
      && $stable(statistics_select) && $stable(alternate_frequency_ratio)) else $error("settings moved");
   alt_toggle_a: assert property (frame_edge ##0 frame_is_alt |=> !frame_is_alt) else $error("alt twice");
   alt_gate_a: assert property (!alternate_frame_enable |-> !frame_is_alt) else $error("alt when off");
   pair_done_a: assert property (pair_end |=> unwrap_pair_done) else $error("pair done missing");
   pair_cause_a: assert property (unwrap_pair_done |-> $past(frame_start && ce && frame_is_alt
      && alternate_frame_enable && dual_frequency_unwrap_enable)) else $error("pair done spurious");
   corr_valid_a: assert property (phase_valid && ce |=> corr_phase_valid) else $error("corr late");
   corr_hold_a: assert property (!(phase_valid && ce) |=> !corr_phase_valid && $stable(corr_phase))
      else $error("corr moved");
endmodule : dpdc_properties
bind dpdc_top dpdc_properties u_props (
   .core_clk(core_clk),
   .rst(rst),
   .ce(ce),
   .frame_start(frame_start),
   .phase_valid(phase_valid),
   .corr_phase_valid(corr_phase_valid),
   .corr_phase(corr_phase),
   .frame_is_alt(frame_is_alt),
   .dual_frequency_unwrap_enable(dual_frequency_unwrap_enable),
   .alternate_frame_enable(alternate_frame_enable),
   .alternate_frequency_ratio(alternate_frequency_ratio),
   .supplementary_subframe_count(supplementary_subframe_count),
   .statistics_select(statistics_select),
   .unwrap_pair_done(unwrap_pair_done)
);

/* File: dv/dpdc_top_bench.sv */
`timescale 1ns/100ps
module dpdc_top_bench;
   import dpdc_pkg::*;
   logic core_clk, rst, ce, psel, penable, pwrite, frame_start, phase_valid, pready, pslverr, er, pd;
   logic corr_phase_valid, frame_is_alt, dual_frequency_unwrap_enable, alternate_frame_enable;
   logic statistics_select, unwrap_pair_done;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [PHASE_W-1:0] phase_data, corr_phase;
   logic [6:0] alternate_frequency_ratio, supplementary_subframe_count;
   logic [6:0] rt [8] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00, 7'h01};
   int error_cnt, samples_checked;
   localparam logic [11:0] A_SUP = {2'h0, IDX_SUPP_OFFSET, 2'h0};
   localparam logic [11:0] A_DIR = {2'h0, IDX_PHASE_DIR, 2'h0};
   localparam logic [11:0] A_ALT = {2'h0, IDX_ALT_FRAME, 2'h0};
   localparam logic [11:0] A_OUT = {2'h0, IDX_OUT_CONTENT, 2'h0};
   dpdc_top u_dut (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .frame_start(frame_start),
      .phase_valid(phase_valid),
      .phase_data(phase_data),
      .corr_phase_valid(corr_phase_valid),
      .corr_phase(corr_phase),
      .frame_is_alt(frame_is_alt),
      .dual_frequency_unwrap_enable(dual_frequency_unwrap_enable),
      .alternate_frame_enable(alternate_frame_enable),
      .alternate_frequency_ratio(alternate_frequency_ratio),
      .supplementary_subframe_count(supplementary_subframe_count),
      .statistics_select(statistics_select),
      .unwrap_pair_done(unwrap_pair_done)
   );
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20) begin
         error_cnt++;
         end_sim();
      end
      // idle cycle so the next setup never reassigns psel in this time step
      @(posedge core_clk);
   endtask : apb
   task automatic frame;
      frame_start <= 1'h1;
      @(posedge core_clk);
      frame_start <= 1'h0;
      #1;
      pd = unwrap_pair_done;
      @(posedge core_clk);
   endtask : frame
   task automatic ph(input logic [11:0] p, input logic [11:0] x);
      phase_valid <= 1'h1;
      phase_data <= p;
      @(posedge core_clk);
      phase_valid <= 1'h0;
      #1;
      chk("corr_valid", 32'h1, corr_phase_valid);
      chk("corr_phase", x, corr_phase);
      @(posedge core_clk);
   endtask : ph
   task automatic t_regs;
      apb(1'h0, A_SUP, 32'h0);
      chk("supp_reg", 32'h0, rd);
      apb(1'h0, A_DIR, 32'h0);
      chk("dir_reg", 32'h80000, rd);
      apb(1'h0, A_ALT, 32'h0);
      chk("alt_reg", 32'h1e008, rd);
      apb(1'h0, A_OUT, 32'h0);
      chk("out_reg", 32'h21090f, rd);
      chk("subframes", 32'h4, supplementary_subframe_count);
      chk("ready", 32'h1, pready);
      apb(1'h0, 12'h3f0, 32'h0);
      chk("bad_addr", 32'h1, er);
      $display("test regs done");
   endtask : t_regs
   task automatic t_ratio;
      for (int i = 1; i < 9; i++) begin
         apb(1'h1, A_ALT, {20'h0001e, 1'h0, 3'(i), 8'h08});
         chk("ratio_held", {25'h0, rt[i-1]}, alternate_frequency_ratio);
         frame;
         chk("ratio", {25'h0, rt[i%8]}, alternate_frequency_ratio);
      end
      $display("test ratio done");
   endtask : t_ratio
   task automatic t_alt;
      apb(1'h1, A_SUP, 32'h10);
      apb(1'h1, A_DIR, 32'h81ffb);
      apb(1'h1, A_ALT, 32'h1e841);
      frame;
      chk("is_alt", 32'h1, frame_is_alt);
      chk("alt_en", 32'h1, alternate_frame_enable);
      chk("unwrap_en", 32'h1, dual_frequency_unwrap_enable);
      chk("subframes", 32'h20, supplementary_subframe_count);
      ph(12'h064, 12'h074);
      frame;
      chk("pair_done", 32'h1, pd);
      chk("is_alt", 32'h0, frame_is_alt);
      ph(12'h064, 12'h05f);
      frame;
      chk("pair_done", 32'h0, pd);
      apb(1'h1, A_ALT, 32'h1e008);
      apb(1'h1, A_DIR, 32'h1800);
      frame;
      frame;
      ph(12'h001, 12'h7ff);
      $display("test alt done");
   endtask : t_alt
   task automatic t_stats;
      apb(1'h1, A_OUT, 32'h21092f);
      chk("stats_held", 32'h0, statistics_select);
      frame;
      chk("stats", 32'h1, statistics_select);
      apb(1'h0, A_OUT, 32'h0);
      chk("out_back", 32'h21092f, rd);
      $display("test stats done");
   endtask : t_stats
   task automatic t_ce;
      apb(1'h1, A_OUT, 32'h21090f);
      ce <= 1'h0;
      frame;
      chk("ce_frame", 32'h1, statistics_select);
      apb(1'h1, A_DIR, 32'h80005);
      ce <= 1'h1;
      apb(1'h0, A_DIR, 32'h0);
      chk("ce_write", 32'h1800, rd);
      frame;
      chk("ce_stats", 32'h0, statistics_select);
      $display("test ce done");
   endtask : t_ce
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      rst = 1'h1;
      ce = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = '0;
      frame_start = 1'h0;
      phase_valid = 1'h0;
      phase_data = '0;
      repeat (12) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      t_regs();
      t_ratio();
      t_alt();
      t_stats();
      t_ce();
      end_sim();
   end
endmodule : dpdc_top_bench
